// ---- logic/afsc_fan_ctrl.sv ----
// top: automatic speed control for two fans with registers and tree test enable
`timescale 1ns/1ns
module afsc_fan_ctrl
  import afsc_pkg::*;
#(
  parameter int unsigned UPDATE_CYCLES    = AFSC_UPDATE_CYCLES,
  parameter int unsigned START_WIN_CYCLES = AFSC_START_WIN_CYCLES,
  parameter logic [63:0] STEP_TABLE       = 64'h30_20_18_10_08_04_02_01
) (
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_resetn,
  // register port
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  input  wire logic                  i_reg_wr,
  output logic      [7:0]            o_reg_rdata,
  // temperatures: 0 thermistor one/second remote, 1 thermistor two, 2 remote, 3 local
  input  wire logic [3:0][7:0]       i_temp_chan,
  input  wire afsc_fan_param_t [1:0] i_fan_param,
  input  wire logic [1:0][7:0]       i_fan_speed,
  input  wire logic                  i_overtemp_limit_event,
  // fan pins
  input  wire logic [1:0]            i_tach,
  output logic      [7:0]            o_fan_drive_out_one,
  output logic      [7:0]            o_fan_drive_out_two,
  output logic                       o_fan_one_power_out,
  output logic                       o_fan_stall_out,
  output logic                       o_tree_test_mode
);
  logic [1:0][7:0]  cfg_reg, cfg_next;
  logic [1:0][7:0]  ceil_reg, ceil_next;
  logic [7:0]       smooth_reg, smooth_next;
  logic [7:0]       tree_reg, tree_next;
  logic [7:0]       rdata_reg, rdata_next;
  logic [31:0]      tick_cnt_reg, tick_cnt_next;
  logic             tick_reg, tick_next;
  afsc_state_t [1:0] state_reg, state_next;
  logic [1:0][31:0] timer_reg, timer_next;
  logic [1:0][1:0]  pulses_reg, pulses_next;
  logic [1:0][2:0]  retries_reg, retries_next;
  logic [1:0][7:0]  level_reg, level_next;
  logic [1:0][7:0]  auto_reg, auto_next;
  logic [1:0][7:0]  drive_reg, drive_next;
  logic [1:0]       stall_reg, stall_next;
  logic             power_reg, power_next;
  logic [1:0]       tach_pulse;

  for (genvar g = 0; g < 2; g++) begin : g_tach
    afsc_tach_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_tach     (i_tach[g]),
      .o_pulse    (tach_pulse[g])
    );
  end

  // linear map of one temperature onto the drive curve
  function automatic logic [7:0] curve(input logic [7:0] t, input afsc_fan_param_t p);
    logic [8:0]  over;
    logic [15:0] prod;
    logic [15:0] q;
    over = {1'b0, t} - {1'b0, p.start_temp};
    prod = 16'(over[7:0]) * 16'(AFSC_DRIVE_FULL - p.min_drive);
    q    = (p.temp_span == 8'h00) ? 16'hFFFF : prod / 16'(p.temp_span);
    if (t <= p.start_temp) begin
      curve = p.min_drive;
    end else if (over[7:0] >= p.temp_span) begin
      curve = AFSC_DRIVE_FULL;
    end else begin
      curve = (q > 16'(AFSC_DRIVE_FULL - p.min_drive)) ? AFSC_DRIVE_FULL
              : p.min_drive + q[7:0];
    end
  endfunction

  // registers and read path
  always_comb begin
    cfg_next    = cfg_reg;
    ceil_next   = ceil_reg;
    smooth_next = smooth_reg;
    tree_next   = tree_reg;
    if (i_reg_wr) begin
      case (i_reg_addr)
        AFSC_ADDR_FAN_ONE_CFG:  cfg_next[0]  = i_reg_wdata;
        AFSC_ADDR_FAN_TWO_CFG:  cfg_next[1]  = i_reg_wdata;
        AFSC_ADDR_FAN_ONE_CEIL: ceil_next[0] = i_reg_wdata;
        AFSC_ADDR_FAN_TWO_CEIL: ceil_next[1] = i_reg_wdata;
        AFSC_ADDR_STEP_SMOOTH:  smooth_next  = i_reg_wdata;
        AFSC_ADDR_TREE_TEST:    tree_next    = i_reg_wdata;
        default: ;
      endcase
    end
    case (i_reg_addr)
      AFSC_ADDR_FAN_ONE_CFG:  rdata_next = cfg_reg[0];
      AFSC_ADDR_FAN_TWO_CFG:  rdata_next = cfg_reg[1];
      AFSC_ADDR_FAN_ONE_CEIL: rdata_next = ceil_reg[0];
      AFSC_ADDR_FAN_TWO_CEIL: rdata_next = ceil_reg[1];
      AFSC_ADDR_STEP_SMOOTH:  rdata_next = smooth_reg;
      AFSC_ADDR_TREE_TEST:    rdata_next = tree_reg;
      default:                rdata_next = 8'h00;
    endcase
  end

  // update interval tick
  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
    if (tick_cnt_reg >= 32'(UPDATE_CYCLES - 1)) begin
      tick_cnt_next = 32'h0000_0000;
      tick_next     = 1'b1;
    end
  end

  // per-fan loop
  always_comb begin
    logic       hot;
    logic       cold;
    logic [7:0] demand;
    logic [7:0] cand;
    logic [7:0] target;
    logic [7:0] step;
    logic [7:0] diff;
    logic [8:0] raised;
    logic       smooth_en;
    logic [2:0] code;
    afsc_fan_param_t p;
    hot = 1'b0;
    cold = 1'b1;
    demand = 8'h00;
    cand = 8'h00;
    target = 8'h00;
    step = 8'h00;
    diff = 8'h00;
    raised = 9'h000;
    smooth_en = 1'b0;
    code = 3'h0;
    p = '0;
    state_next   = state_reg;
    timer_next   = timer_reg;
    pulses_next  = pulses_reg;
    retries_next = retries_reg;
    level_next   = level_reg;
    auto_next    = auto_reg;
    stall_next   = stall_reg;
    drive_next   = drive_reg;
    for (int f = 0; f < 2; f++) begin
      p      = i_fan_param[f];
      hot    = 1'b0;
      cold   = 1'b1;
      demand = 8'h00;
      for (int c = 0; c < 4; c++) begin
        if (cfg_reg[f][AFSC_CFG_SRC_LSB + c]) begin
          if (i_temp_chan[c] > p.start_temp) hot = 1'b1;
          if ({1'b0, i_temp_chan[c]} + {1'b0, p.off_hyst} >= {1'b0, p.start_temp}) begin
            cold = 1'b0;
          end
          cand = curve(i_temp_chan[c], p);
          if (cand > demand) demand = cand;
        end
      end
      code      = (f == 0) ? smooth_reg[AFSC_SM_CODE_ONE +: 3]
                           : smooth_reg[AFSC_SM_CODE_TWO +: 3];
      smooth_en = (f == 0) ? smooth_reg[AFSC_SM_EN_ONE] : smooth_reg[AFSC_SM_EN_TWO];
      step      = STEP_TABLE[8*code +: 8];
      if (cfg_reg[f][AFSC_CFG_MAX:AFSC_CFG_MANUAL] != 4'h0) begin
        state_next[f]   = AFSC_ST_OFF;
        auto_next[f]    = AFSC_DRIVE_ZERO;
        timer_next[f]   = 32'h0000_0000;
      end else begin
        case (state_reg[f])
          AFSC_ST_OFF: begin
            if (hot) begin
              state_next[f]   = AFSC_ST_START;
              level_next[f]   = p.start_drive;
              retries_next[f] = 3'h0;
              pulses_next[f]  = 2'h0;
              timer_next[f]   = 32'h0000_0000;
            end
          end
          AFSC_ST_START: begin
            timer_next[f] = timer_reg[f] + 32'h0000_0001;
            if (tach_pulse[f]) pulses_next[f] = pulses_reg[f] + 2'h1;
            if (tach_pulse[f] && pulses_reg[f] == 2'(AFSC_START_PULSES - 1)) begin
              state_next[f] = AFSC_ST_RUN;
              auto_next[f]  = p.min_drive;
              stall_next[f] = 1'b0;
            end else if (timer_reg[f] >= 32'(START_WIN_CYCLES - 1)) begin
              raised          = {1'b0, level_reg[f]} + {1'b0, p.start_step};
              timer_next[f]   = 32'h0000_0000;
              pulses_next[f]  = 2'h0;
              if (retries_reg[f] < 3'(AFSC_MAX_RETRIES) && level_reg[f] != AFSC_DRIVE_FULL) begin
                retries_next[f] = retries_reg[f] + 3'h1;
                level_next[f]   = raised[8] ? AFSC_DRIVE_FULL : raised[7:0];
              end else begin
                stall_next[f] = 1'b1;
                state_next[f] = AFSC_ST_WAIT;
              end
            end
          end
          AFSC_ST_RUN: begin
            if (tick_reg) begin
              if (cold && !p.keep_running) begin
                state_next[f] = AFSC_ST_OFF;
                auto_next[f]  = AFSC_DRIVE_ZERO;
              end else begin
                target = hot ? demand : p.min_drive;
                if (ceil_reg[f] != 8'h00 && i_fan_speed[f] >= ceil_reg[f]
                    && target > auto_reg[f]) begin
                  target = auto_reg[f];
                end
                if (!smooth_en) begin
                  auto_next[f] = target;
                end else if (target > auto_reg[f]) begin
                  diff = target - auto_reg[f];
                  auto_next[f] = (diff > step) ? auto_reg[f] + step : target;
                end else begin
                  diff = auto_reg[f] - target;
                  auto_next[f] = (diff > step) ? auto_reg[f] - step : target;
                end
              end
            end
          end
          AFSC_ST_WAIT: begin
            if (tick_reg) timer_next[f] = timer_reg[f] + 32'h0000_0001;
            if (timer_reg[f] >= 32'(AFSC_RETRY_WAIT_TICKS)) begin
              state_next[f]   = AFSC_ST_START;
              level_next[f]   = p.start_drive;
              retries_next[f] = 3'h0;
              pulses_next[f]  = 2'h0;
              timer_next[f]   = 32'h0000_0000;
            end
          end
          default: state_next[f] = AFSC_ST_OFF;
        endcase
      end
      // output priority: overtemp, maximum, start, minimum, manual, loop
      if (i_overtemp_limit_event) begin
        drive_next[f] = AFSC_DRIVE_FULL;
      end else if (cfg_reg[f][AFSC_CFG_MAX]) begin
        drive_next[f] = AFSC_DRIVE_FULL;
      end else if (cfg_reg[f][AFSC_CFG_START]) begin
        drive_next[f] = p.start_drive;
      end else if (cfg_reg[f][AFSC_CFG_MIN]) begin
        drive_next[f] = p.min_drive;
      end else if (cfg_reg[f][AFSC_CFG_MANUAL]) begin
        drive_next[f] = p.manual_drive;
      end else begin
        case (state_next[f])
          AFSC_ST_START: drive_next[f] = level_next[f];
          AFSC_ST_RUN:   drive_next[f] = auto_next[f];
          default:       drive_next[f] = AFSC_DRIVE_ZERO;
        endcase
      end
    end
    power_next = (drive_next[0] != AFSC_DRIVE_ZERO);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      cfg_reg      <= {AFSC_RST_FAN_CFG, AFSC_RST_FAN_CFG};
      ceil_reg     <= {AFSC_RST_CEIL, AFSC_RST_CEIL};
      smooth_reg   <= AFSC_RST_SMOOTH;
      tree_reg     <= AFSC_RST_TREE_TEST;
      rdata_reg    <= 8'h00;
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
      state_reg    <= '{AFSC_ST_OFF, AFSC_ST_OFF};
      timer_reg    <= '0;
      pulses_reg   <= '0;
      retries_reg  <= '0;
      level_reg    <= '0;
      auto_reg     <= '0;
      drive_reg    <= '0;
      stall_reg    <= 2'b00;
      power_reg    <= 1'b0;
    end else begin
      cfg_reg      <= cfg_next;
      ceil_reg     <= ceil_next;
      smooth_reg   <= smooth_next;
      tree_reg     <= tree_next;
      rdata_reg    <= rdata_next;
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
      state_reg    <= state_next;
      timer_reg    <= timer_next;
      pulses_reg   <= pulses_next;
      retries_reg  <= retries_next;
      level_reg    <= level_next;
      auto_reg     <= auto_next;
      drive_reg    <= drive_next;
      stall_reg    <= stall_next;
      power_reg    <= power_next;
    end
  end

  assign o_reg_rdata         = rdata_reg;
  assign o_fan_drive_out_one = drive_reg[0];
  assign o_fan_drive_out_two = drive_reg[1];
  assign o_fan_one_power_out = power_reg;
  assign o_fan_stall_out     = |stall_reg;
  assign o_tree_test_mode    = tree_reg[AFSC_TREE_BIT];
endmodule // afsc_fan_ctrl

// ---- logic/afsc_pkg.sv ----
// package: constants and types for the two-fan automatic speed controller
package afsc_pkg;
  // register offsets
  localparam logic [7:0] AFSC_ADDR_FAN_ONE_CFG  = 8'h05;
  localparam logic [7:0] AFSC_ADDR_FAN_TWO_CFG  = 8'h06;
  localparam logic [7:0] AFSC_ADDR_FAN_ONE_CEIL = 8'h34;
  localparam logic [7:0] AFSC_ADDR_FAN_TWO_CEIL = 8'h35;
  localparam logic [7:0] AFSC_ADDR_STEP_SMOOTH  = 8'h36;
  localparam logic [7:0] AFSC_ADDR_TREE_TEST    = 8'h42;
  // reset values
  localparam logic [7:0] AFSC_RST_FAN_CFG   = 8'h0C;
  localparam logic [7:0] AFSC_RST_CEIL      = 8'h00;
  localparam logic [7:0] AFSC_RST_SMOOTH    = 8'h00;
  localparam logic [7:0] AFSC_RST_TREE_TEST = 8'h00;
  // fan configuration fields
  localparam int AFSC_CFG_SRC_LSB  = 0;
  localparam int AFSC_CFG_MANUAL   = 4;
  localparam int AFSC_CFG_MIN      = 5;
  localparam int AFSC_CFG_START    = 6;
  localparam int AFSC_CFG_MAX      = 7;
  // smoothing register fields and tree test bit
  localparam int AFSC_SM_CODE_ONE  = 0;
  localparam int AFSC_SM_CODE_TWO  = 3;
  localparam int AFSC_SM_EN_ONE    = 6;
  localparam int AFSC_SM_EN_TWO    = 7;
  localparam int AFSC_TREE_BIT     = 0;
  // drive levels
  localparam logic [7:0] AFSC_DRIVE_FULL = 8'hFF;
  localparam logic [7:0] AFSC_DRIVE_ZERO = 8'h00;
  // timing
  localparam int unsigned AFSC_CLK_HZ         = 125_000_000;
  localparam int unsigned AFSC_UPDATE_MS      = 250;
  localparam int unsigned AFSC_UPDATE_CYCLES  = AFSC_CLK_HZ / 1000 * AFSC_UPDATE_MS;
  localparam int unsigned AFSC_START_WIN_MS   = 2000;
  localparam int unsigned AFSC_START_WIN_CYCLES = AFSC_CLK_HZ / 1000 * AFSC_START_WIN_MS;
  localparam int unsigned AFSC_RETRY_WAIT_S   = 60;
  localparam int unsigned AFSC_RETRY_WAIT_TICKS = AFSC_RETRY_WAIT_S * 1000 / AFSC_UPDATE_MS;
  localparam int unsigned AFSC_MAX_RETRIES    = 5;
  localparam int unsigned AFSC_START_PULSES   = 2;

  typedef enum logic [1:0] {
    AFSC_ST_OFF   = 2'b00,
    AFSC_ST_START = 2'b01,
    AFSC_ST_RUN   = 2'b10,
    AFSC_ST_WAIT  = 2'b11
  } afsc_state_t;

  // per-fan loop settings held outside this block
  typedef struct packed {
    logic [7:0] start_temp;
    logic [7:0] temp_span;
    logic [7:0] off_hyst;
    logic [7:0] min_drive;
    logic [7:0] start_drive;
    logic [7:0] start_step;
    logic [7:0] manual_drive;
    logic       keep_running;
  } afsc_fan_param_t;
endpackage

// ---- logic/afsc_tach_sync.sv ----
// three-flop tach synchroniser with one-cycle pulse on each agreed rising edge
`timescale 1ns/1ns
module afsc_tach_sync (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  // tach pin and pulse
  input  wire logic i_tach,
  output logic      o_pulse
);
  logic s1_reg, s2_reg, s3_reg, lvl_reg, pulse_reg;
  logic lvl_next, pulse_next;

  always_comb begin
    lvl_next   = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
    pulse_next = lvl_next & ~lvl_reg;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      // start at the pulled-up idle level so no false edge follows reset
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      lvl_reg   <= 1'b1;
      pulse_reg <= 1'b0;
    end else begin
      s1_reg    <= i_tach;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      lvl_reg   <= lvl_next;
      pulse_reg <= pulse_next;
    end
  end

  assign o_pulse = pulse_reg;
endmodule // afsc_tach_sync

// ---- sim/afsc_fan_model.sv ----
// fan model: tach pin toggles while the fan is driven and its rotor is free
`timescale 1ns/1ns
module afsc_fan_model #(
  parameter int unsigned HALF = 6
) (
  // clock
  input  wire logic       i_clk,
  // rotor state and drive code
  input  wire logic       i_jam,
  input  wire logic [7:0] i_drive,
  // tach pin, pulled up, holds its level while the rotor stands
  output logic            o_tach
);
  int unsigned cnt;
  initial o_tach = 1'b1;
  always @(posedge i_clk) begin
    if (i_drive == 8'h00) begin
      // unpowered fan releases the pin to its pull-up
      cnt    <= 0;
      o_tach <= 1'b1;
    end else if (i_jam) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      o_tach <= !o_tach;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // afsc_fan_model

// ---- sim/afsc_fan_ctrl_sva.sv ----
// checker: port-level assertions for the two-fan speed controller
`timescale 1ns/1ns
module afsc_fan_ctrl_sva
  import afsc_pkg::*;
(
  // clock and reset
  input wire logic                  i_core_clk,
  input wire logic                  i_resetn,
  // register port
  input wire logic [7:0]            i_reg_addr,
  input wire logic [7:0]            i_reg_wdata,
  input wire logic                  i_reg_wr,
  input wire logic [7:0]            o_reg_rdata,
  // loop inputs and outputs
  input wire afsc_fan_param_t [1:0] i_fan_param,
  input wire logic                  i_overtemp_limit_event,
  input wire logic [7:0]            o_fan_drive_out_one,
  input wire logic [7:0]            o_fan_drive_out_two,
  input wire logic                  o_tree_test_mode
);
  logic [7:0] cfg1_reg;
  logic [7:0] cfg1_next;
  logic [7:0] cfg2_reg;
  logic [7:0] cfg2_next;
  logic       calm_reg;
  logic       calm_next;
  logic       mapped;
  assign mapped = i_reg_addr inside {AFSC_ADDR_FAN_ONE_CFG, AFSC_ADDR_FAN_TWO_CFG,
    AFSC_ADDR_FAN_ONE_CEIL, AFSC_ADDR_FAN_TWO_CEIL, AFSC_ADDR_STEP_SMOOTH, AFSC_ADDR_TREE_TEST};
  // shadow of both configuration registers, and "last cycle ran without overtemp"
  always_comb begin
    cfg1_next = i_resetn ? cfg1_reg : AFSC_RST_FAN_CFG;
    cfg2_next = i_resetn ? cfg2_reg : AFSC_RST_FAN_CFG;
    if (i_resetn && i_reg_wr && i_reg_addr == AFSC_ADDR_FAN_ONE_CFG) cfg1_next = i_reg_wdata;
    if (i_resetn && i_reg_wr && i_reg_addr == AFSC_ADDR_FAN_TWO_CFG) cfg2_next = i_reg_wdata;
    calm_next = i_resetn && !i_overtemp_limit_event;
  end
  always_ff @(posedge i_core_clk) begin
    cfg1_reg <= cfg1_next;
    cfg2_reg <= cfg2_next;
    calm_reg <= calm_next;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  unmapped_read_a: assert property (
    !$past(mapped) |-> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  reg_readback_a: assert property (
    (i_reg_wr && mapped) ##1 ($stable(i_reg_addr) && !i_reg_wr)
    |-> ##1 o_reg_rdata == $past(i_reg_wdata, 2)) else $error("register readback wrong");
  tree_mode_a: assert property (
    (i_reg_wr && i_reg_addr == AFSC_ADDR_TREE_TEST) ##1 !i_reg_wr
    |-> ##1 o_tree_test_mode == $past(i_reg_wdata[AFSC_TREE_BIT], 2))
    else $error("tree test mode wrong");
  overtemp_full_a: assert property (
    $past(i_overtemp_limit_event) && $past(i_resetn) |-> o_fan_drive_out_one == AFSC_DRIVE_FULL
    && o_fan_drive_out_two == AFSC_DRIVE_FULL) else $error("overtemp drive not full");
  max_one_a: assert property (
    calm_reg && $past(cfg1_reg[AFSC_CFG_MAX]) |-> o_fan_drive_out_one == AFSC_DRIVE_FULL)
    else $error("fan one max drive wrong");
  start_one_a: assert property (
    calm_reg && $past(cfg1_reg[7:6]) == 2'b01
    |-> o_fan_drive_out_one == $past(i_fan_param[0].start_drive))
    else $error("fan one start drive wrong");
  min_one_a: assert property (
    calm_reg && $past(cfg1_reg[7:5]) == 3'b001
    |-> o_fan_drive_out_one == $past(i_fan_param[0].min_drive))
    else $error("fan one min drive wrong");
  manual_one_a: assert property (
    calm_reg && $past(cfg1_reg[7:4]) == 4'b0001
    |-> o_fan_drive_out_one == $past(i_fan_param[0].manual_drive))
    else $error("fan one manual drive wrong");
  max_two_a: assert property (
    calm_reg && $past(cfg2_reg[AFSC_CFG_MAX]) |-> o_fan_drive_out_two == AFSC_DRIVE_FULL)
    else $error("fan two max drive wrong");
endmodule // afsc_fan_ctrl_sva

bind afsc_fan_ctrl afsc_fan_ctrl_sva u_sva (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .o_reg_rdata(o_reg_rdata),
  .i_fan_param(i_fan_param), .i_overtemp_limit_event(i_overtemp_limit_event),
  .o_fan_drive_out_one(o_fan_drive_out_one), .o_fan_drive_out_two(o_fan_drive_out_two),
  .o_tree_test_mode(o_tree_test_mode)
);

// ---- sim/tb.sv ----
// testbench: registers, overrides, loop curve, ceiling, smoothing and stall retry
`timescale 1ns/1ns
module tb;
  import afsc_pkg::*;
  logic                  clk;
  logic                  rst_n;
  logic [7:0]            addr;
  logic [7:0]            wdata;
  logic                  wr;
  logic [7:0]            rdata;
  logic [3:0][7:0]       temp;
  afsc_fan_param_t [1:0] prm;
  logic [1:0][7:0]       spd;
  logic                  ot;
  logic [1:0]            tach;
  logic [1:0]            jam;
  logic [7:0]            d1;
  logic [7:0]            d2;
  logic                  pwr;
  logic                  stall;
  logic                  tree;
  int                    num_errors;
  int                    num_checks;

  afsc_fan_ctrl #(.UPDATE_CYCLES(20), .START_WIN_CYCLES(50)) dut (
    .i_core_clk(clk), .i_resetn(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .o_reg_rdata(rdata), .i_temp_chan(temp), .i_fan_param(prm),
    .i_fan_speed(spd), .i_overtemp_limit_event(ot), .i_tach(tach),
    .o_fan_drive_out_one(d1), .o_fan_drive_out_two(d2), .o_fan_one_power_out(pwr),
    .o_fan_stall_out(stall), .o_tree_test_mode(tree));
  afsc_fan_model fan_one (.i_clk(clk), .i_jam(jam[0]), .i_drive(d1), .o_tach(tach[0]));
  afsc_fan_model fan_two (.i_clk(clk), .i_jam(jam[1]), .i_drive(d2), .o_tach(tach[1]));

  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end

  task automatic summarize;
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1 chk(rdata, e);
  endtask
  // poll one fan's drive until it shows the expected code, bounded
  task automatic wait_dr(input bit f, input logic [7:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if ((f ? d2 : d1) === e) break;
    end
    chk(f ? d2 : d1, e);
    @(posedge clk);
  endtask
  task automatic wait_st(input logic e, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (stall === e) break;
    end
    chk({7'h00, stall}, {7'h00, e});
    @(posedge clk);
  endtask

  task automatic t_regs;
    rd_chk(AFSC_ADDR_FAN_ONE_CFG, AFSC_RST_FAN_CFG);
    rd_chk(AFSC_ADDR_FAN_ONE_CEIL, AFSC_RST_CEIL);
    rd_chk(AFSC_ADDR_STEP_SMOOTH, AFSC_RST_SMOOTH);
    wr_reg(AFSC_ADDR_FAN_TWO_CFG, 8'h00);
    wr_reg(AFSC_ADDR_STEP_SMOOTH, 8'hA5);
    wr_reg(AFSC_ADDR_TREE_TEST, 8'h01);
    wr_reg(8'h07, 8'h5A);
    rd_chk(AFSC_ADDR_STEP_SMOOTH, 8'hA5);
    rd_chk(AFSC_ADDR_FAN_TWO_CFG, 8'h00);
    rd_chk(8'h07, 8'h00);
    chk({7'h00, tree}, 8'h01);
    wr_reg(AFSC_ADDR_TREE_TEST, 8'h00);
    wr_reg(AFSC_ADDR_STEP_SMOOTH, 8'h00);
    rd_chk(AFSC_ADDR_TREE_TEST, 8'h00);
  endtask
  task automatic t_over;
    wr_reg(AFSC_ADDR_FAN_ONE_CEIL, 8'h00);
    wr_reg(AFSC_ADDR_FAN_TWO_CEIL, 8'h00);
    wr_reg(AFSC_ADDR_FAN_ONE_CFG, 8'hFF);
    wait_dr(0, 8'hFF, 4);
    wr_reg(AFSC_ADDR_FAN_TWO_CFG, 8'h80);
    wait_dr(1, 8'hFF, 4);
    wr_reg(AFSC_ADDR_FAN_TWO_CFG, 8'h00);
    wr_reg(AFSC_ADDR_FAN_ONE_CFG, 8'h7F);
    wait_dr(0, 8'h60, 4);
    wr_reg(AFSC_ADDR_FAN_ONE_CFG, 8'h3F);
    wait_dr(0, 8'h40, 4);
    wr_reg(AFSC_ADDR_FAN_ONE_CFG, 8'h1F);
    wait_dr(0, 8'h55, 4);
    ot <= 1'b1;
    wait_dr(0, 8'hFF, 4);
    wait_dr(1, 8'hFF, 4);
    ot <= 1'b0;
    wait_dr(0, 8'h55, 4);
    wr_reg(AFSC_ADDR_FAN_ONE_CFG, 8'h00);
  endtask
  task automatic t_loop;
    wr_reg(AFSC_ADDR_FAN_ONE_CEIL, 8'h80);
    wr_reg(AFSC_ADDR_FAN_ONE_CFG, 8'h0C);
    temp[3] <= 8'h50;
    wait_dr(0, 8'h60, 60);
    #1 chk({7'h00, pwr}, 8'h01);
    wait_dr(0, 8'h40, 60);
    wait_dr(0, 8'h9F, 60);
    spd[0] <= 8'h80;
    temp[2] <= 8'h70;
    repeat (60) @(posedge clk);
    wait_dr(0, 8'h9F, 1);
    ot <= 1'b1;
    wait_dr(0, 8'hFF, 4);
    ot <= 1'b0;
    wait_dr(0, 8'h9F, 4);
    spd[0] <= 8'h00;
    wait_dr(0, 8'hFF, 30);
    temp[2] <= 8'h20;
    wait_dr(0, 8'h9F, 30);
    wr_reg(AFSC_ADDR_STEP_SMOOTH, 8'h42);
    temp[3] <= 8'h70;
    wait_dr(0, 8'hA3, 30);
    wait_dr(0, 8'hA7, 30);
    wr_reg(AFSC_ADDR_STEP_SMOOTH, 8'h00);
    temp[3] <= 8'h2C;
    wait_dr(0, 8'h40, 100);
    prm[0].keep_running <= 1'b1;
    temp[3] <= 8'h20;
    repeat (30) @(posedge clk);
    wait_dr(0, 8'h40, 1);
    prm[0].keep_running <= 1'b0;
    wait_dr(0, 8'h00, 60);
    #1 chk({7'h00, pwr}, 8'h00);
  endtask
  task automatic t_stall;
    int s;
    wr_reg(AFSC_ADDR_FAN_TWO_CFG, 8'h01);
    jam[1] <= 1'b1;
    temp[0] <= 8'h50;
    for (int i = 0; i < 4; i++) begin
      s = 'hA0 + 'h20 * i;
      wait_dr(1, (s > 'hFF) ? 8'hFF : s[7:0], 80);
    end
    wait_st(1'b1, 80);
    wait_dr(1, 8'h00, 1);
    jam[1] <= 1'b0;
    wait_dr(1, 8'hA0, 5200);
    wait_st(1'b0, 80);
  endtask

  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    num_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    temp = {4{8'h10}};
    prm[0] = '{8'h30, 8'h40, 8'h08, 8'h40, 8'h60, 8'h10, 8'h55, 1'b0};
    prm[1] = '{8'h30, 8'h40, 8'h08, 8'h40, 8'hA0, 8'h20, 8'h55, 1'b0};
    spd = '0;
    ot = 1'b0;
    jam = 2'b00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_over();
    t_loop();
    t_stall();
    summarize();
  end
endmodule // tb
